// ===== include/event_timer_pkg.sv
// event timer package: register map, field positions, reset values, carrier types
// assumes a 32-bit ahb-lite register bus with word-aligned registers
package event_timer_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET     = 8'h00;
   localparam logic [7:0] PRESCALE_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET   = 8'h08;
   localparam logic [7:0] PORT_OFFSET     = 8'h0c;
   localparam logic [7:0] COUNT_OFFSET    = 8'h10;

   // control register fields
   localparam int unsigned CTRL_SRC_BIT   = 0;
   localparam int unsigned CTRL_MODE_BIT  = 1;
   localparam int unsigned CTRL_LEVEL_BIT = 2;
   localparam int unsigned CTRL_OE_BIT    = 3;
   localparam int unsigned CTRL_EDGE_BIT  = 4;

   // prescale register fields
   localparam int unsigned RATE_LOW_BIT  = 0;
   localparam int unsigned RATE_HIGH_BIT = 1;

   // status register fields
   localparam int unsigned STAT_IN_LEVEL_BIT = 0;
   localparam int unsigned STAT_OUT_ON_BIT   = 1;
   localparam int unsigned STAT_DIV_BIT      = 2;
   localparam int unsigned STAT_CLEAR_BIT    = 3;
   localparam int unsigned STAT_FLAG_BIT     = 7;

   // port register fields
   localparam int unsigned PORT_IN_DIR_BIT    = 0;
   localparam int unsigned PORT_OUT_DIR_BIT   = 1;
   localparam int unsigned PORT_IN_LATCH_BIT  = 2;
   localparam int unsigned PORT_OUT_LATCH_BIT = 3;
   localparam int unsigned PORT_IN_PIN_BIT    = 4;

   // counter preset and reset values
   localparam logic [7:0] COUNT_PRESET = 8'h01;
   localparam logic [1:0] RATE_RESET   = 2'h0;

   // prescaler terminal counts: divide by 4, 32, 256
   localparam logic [7:0] DIV4_MASK   = 8'h03;
   localparam logic [7:0] DIV32_MASK  = 8'h1f;
   localparam logic [7:0] DIV256_MASK = 8'hff;

   // clock rate
   localparam int unsigned REF_CLK_PERIOD_NS = 100;

   // rate select codes
   typedef enum logic [1:0] {
      RATE_DIV1   = 2'b00,
      RATE_DIV4   = 2'b01,
      RATE_DIV32  = 2'b10,
      RATE_DIV256 = 2'b11
   } rate_sel_t;

   // ahb htrans
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   typedef struct packed {
      logic output_edge_select;
      logic output_enable_bit;
      logic input_level_select;
      logic input_mode_select;
      logic count_source_select;
   } ctrl_t;

   typedef struct packed {
      logic output_latch;
      logic input_latch;
      logic output_pin_direction;
      logic input_pin_direction;
   } port_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } ahb_phase_t;

endpackage

// ===== rtl/event_prescaler.sv
// 8-bit free-running prescaler on the system clock
// assumes rate select comes from a register on the same clock
`timescale 1ns/1ps
module event_prescaler
   import event_timer_pkg::*;
(
   // clock and reset
   input  wire logic      ref_clk,
   input  wire logic      rst_n,
   // rate select
   input  wire rate_sel_t rate_sel,
   // one-cycle ticks
   output logic           fixed_quarter_clock,
   output logic           prescaled_timer_clock
);

   logic [7:0] count;
   logic [7:0] next_count;

   function automatic logic at_terminal(input logic [7:0] value, input logic [7:0] mask);
      at_terminal = ((value & mask) == mask);
   endfunction

   always_comb begin
      next_count = count + 8'h01;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 8'h00;
      end else begin
         count <= next_count;
      end
   end

   // quarter rate tick for the other timer
   assign fixed_quarter_clock = at_terminal(count, DIV4_MASK); // RL14

   always_comb begin
      unique case (rate_sel) // RL1
         RATE_DIV1:   prescaled_timer_clock = 1'b1;
         RATE_DIV4:   prescaled_timer_clock = at_terminal(count, DIV4_MASK);
         RATE_DIV32:  prescaled_timer_clock = at_terminal(count, DIV32_MASK);
         RATE_DIV256: prescaled_timer_clock = at_terminal(count, DIV256_MASK);
      endcase
   end

endmodule // event_prescaler

// ===== rtl/event_timer_clock_and_output.sv
// event timer clock source, event input, 8-bit counter and toggle event output
// assumes a single ahb-lite master, and a compare core on the same clock that
// pulses compare_match_pulse for one cycle per match
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// RL1: prescaled timer clock divides system clock by 1, 4, 32, 256; reset zero.
// RL2: event input passes a two-flop synchronizer on the system clock.
// RL3: edge mode counts synchronized edges; level select picks falling or rising.
// RL4: edge mode sets the event input flag on every selected edge.
// RL5: gated mode counts prescaled ticks while input sits at selected level.
// RL6: gated mode sets the flag when input leaves its active level.
// RL7: software presets the counter after changing the input mode select.
// RL8: software keeps the input pin direction clear while the event input is used.
// RL9: toggle stage halves compare match pulses into a 50% duty output.
// RL10: counter write loads the toggle stage with the output edge select level.
// RL11: output enable changes apply only at the selected event output edge.
// RL12: output pin driver enabled by its direction bit or synchronized enable.
// RL13: output off drives port latch if direction set, else released.
// RL14: prescaler supplies a fixed quarter-rate tick to the other timer.
// RL15: prescaled clock also gates gated mode; ticks aligned to system clock.
// RL16: count source select picks prescaled clock at zero, event input at one.
// RL17: output edge select zero means falling edge, one means rising edge.
// RL18: writing one to flag clear clears the flag; clear bit reads zero.
// RL19: a preset in the same cycle as an increment wins; increment dropped.
// RL20: mode and level changes act from the cycle after the write.
module event_timer_clock_and_output
   import event_timer_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // compare core link
   input  wire logic        compare_match_pulse,
   output logic      [7:0]  event_counter,
   output logic             counter_preset,
   output logic             fixed_quarter_clock,
   // shared input pin
   input  wire logic        event_in_pin,
   output logic             shared_input_port_pin_out,
   output logic             shared_input_port_pin_oe,
   // shared output pin
   output logic             event_out_pin_out,
   output logic             event_out_pin_oe
);

   // register state
   ctrl_t      ctrl;
   ctrl_t      next_ctrl;
   rate_sel_t  rate_sel;
   rate_sel_t  next_rate_sel;
   port_t      port;
   port_t      next_port;
   ahb_phase_t phase;
   ahb_phase_t next_phase;
   logic [31:0] next_hrdata;

   // event input state
   logic       in_meta;
   logic       in_sync;
   logic       in_prev;
   logic       event_input_flag;
   logic       next_event_input_flag;

   // counter and output state
   logic [7:0] next_event_counter;
   logic       divider;
   logic       next_divider;
   logic       out_on;
   logic       next_out_on;

   // decoded strobes
   logic       prescaled_timer_clock;
   logic       wr_ctrl;
   logic       wr_prescale;
   logic       wr_status;
   logic       wr_port;
   logic       wr_count;
   logic       event_flag_clear;
   logic       edge_rise;
   logic       edge_fall;
   logic       edge_hit;
   logic       gate_open;
   logic       gate_close;
   logic       external_count_clock;
   logic       count_tick;
   logic       div_edge;

   function automatic logic is_write(input ahb_phase_t p, input logic [7:0] offset);
      is_write = p.valid && p.write && (p.addr == offset);
   endfunction

   event_prescaler u_prescaler (
      .ref_clk               (ref_clk),
      .rst_n                 (rst_n),
      .rate_sel              (rate_sel),
      .fixed_quarter_clock   (fixed_quarter_clock),
      .prescaled_timer_clock (prescaled_timer_clock)
   );

   // bus slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign wr_ctrl     = is_write(phase, CTRL_OFFSET);
   assign wr_prescale = is_write(phase, PRESCALE_OFFSET);
   assign wr_status   = is_write(phase, STATUS_OFFSET);
   assign wr_port     = is_write(phase, PORT_OFFSET);
   assign wr_count    = is_write(phase, COUNT_OFFSET);

   assign event_flag_clear = wr_status && hwdata[STAT_CLEAR_BIT]; // RL18

   always_comb begin
      next_phase.valid = hsel && hready && (htrans == HTRANS_NONSEQ);
      next_phase.write = hwrite;
      next_phase.addr  = {haddr[7:2], 2'b00};
      next_hrdata      = 32'h0000_0000;
      if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite) begin
         unique case ({haddr[7:2], 2'b00})
            CTRL_OFFSET:     next_hrdata[4:0] = ctrl;
            PRESCALE_OFFSET: next_hrdata[1:0] = rate_sel;
            STATUS_OFFSET: begin
               // clear bit is write-only and reads zero
               next_hrdata[STAT_FLAG_BIT]     = event_input_flag; // RL18
               next_hrdata[STAT_IN_LEVEL_BIT] = in_sync;
               next_hrdata[STAT_OUT_ON_BIT]   = out_on;
               next_hrdata[STAT_DIV_BIT]      = divider;
            end
            PORT_OFFSET: begin
               next_hrdata[3:0]             = port;
               next_hrdata[PORT_IN_PIN_BIT] = in_sync;
            end
            COUNT_OFFSET:    next_hrdata[7:0] = event_counter;
            default:         next_hrdata      = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      next_ctrl     = ctrl;
      next_rate_sel = rate_sel;
      next_port     = port;
      if (wr_ctrl) begin
         // new mode and level reach the event logic on the next cycle
         next_ctrl = ctrl_t'(hwdata[4:0]); // RL20
      end
      if (wr_prescale) begin
         next_rate_sel = rate_sel_t'({hwdata[RATE_HIGH_BIT], hwdata[RATE_LOW_BIT]}); // RL1
      end
      if (wr_port) begin
         next_port = port_t'(hwdata[3:0]);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase    <= '0;
         hrdata   <= 32'h0000_0000;
         ctrl     <= '0;
         rate_sel <= RATE_DIV1;
         port     <= '0;
      end else begin
         phase    <= next_phase;
         hrdata   <= next_hrdata;
         ctrl     <= next_ctrl;
         rate_sel <= next_rate_sel;
         port     <= next_port;
      end
   end

   // event input: synchronizer, then edge and gate detection on the second flop
   assign edge_rise  = in_sync && !in_prev;
   assign edge_fall  = !in_sync && in_prev;
   assign edge_hit   = ctrl.input_level_select ? edge_rise : edge_fall; // RL3
   assign gate_open  = (in_sync == ctrl.input_level_select); // RL5
   assign gate_close = ctrl.input_level_select ? edge_fall : edge_rise; // RL6

   always_comb begin
      if (ctrl.input_mode_select) begin
         external_count_clock = prescaled_timer_clock && gate_open; // RL15
      end else begin
         external_count_clock = edge_hit; // RL3
      end
   end

   always_comb begin
      next_event_input_flag = event_input_flag;
      if (event_flag_clear) begin
         next_event_input_flag = 1'b0; // RL18
      end
      // a new event beats a clear in the same cycle
      if (!ctrl.input_mode_select && edge_hit) begin
         next_event_input_flag = 1'b1; // RL4
      end
      if (ctrl.input_mode_select && gate_close) begin
         next_event_input_flag = 1'b1; // RL6
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_meta          <= 1'b0;
         in_sync          <= 1'b0;
         in_prev          <= 1'b0;
         event_input_flag <= 1'b0;
      end else begin
         in_meta          <= event_in_pin; // RL2
         in_sync          <= in_meta; // RL2
         in_prev          <= in_sync;
         event_input_flag <= next_event_input_flag;
      end
   end

   // counter: source select, preset overrides increment
   assign count_tick     = ctrl.count_source_select ? external_count_clock
                                                    : prescaled_timer_clock; // RL16
   assign counter_preset = wr_count || compare_match_pulse;

   always_comb begin
      next_event_counter = event_counter;
      if (counter_preset) begin
         next_event_counter = COUNT_PRESET; // RL19
      end else if (count_tick) begin
         next_event_counter = event_counter + 8'h01;
      end
   end

   // output toggle divider and edge-synchronized enable
   always_comb begin
      next_divider = divider;
      if (wr_count) begin
         next_divider = ctrl.output_edge_select; // RL10
      end else if (compare_match_pulse) begin
         next_divider = !divider; // RL9
      end
   end

   // selected edge: rising when edge select is one, falling when zero
   assign div_edge = !wr_count && (next_divider != divider)
                     && (next_divider == ctrl.output_edge_select); // RL17

   always_comb begin
      next_out_on = out_on;
      if (div_edge) begin
         next_out_on = ctrl.output_enable_bit; // RL11
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_counter <= COUNT_PRESET;
         divider       <= 1'b0;
         out_on        <= 1'b0;
      end else begin
         event_counter <= next_event_counter;
         divider       <= next_divider;
         out_on        <= next_out_on;
      end
   end

   // shared pins
   assign event_out_pin_oe  = port.output_pin_direction || out_on; // RL12
   assign event_out_pin_out = out_on ? divider : port.output_latch; // RL13

   // input pin works as a port output only when its direction bit is set
   assign shared_input_port_pin_oe  = port.input_pin_direction;
   assign shared_input_port_pin_out = port.input_latch;

endmodule // event_timer_clock_and_output

// ===== dv/event_timer_clock_and_output_monitor.sv
// checker of bus, counter, prescaler and event output relations
// sees only top module ports; attached by the bind at the foot
`timescale 1ns/1ps
module event_timer_clock_and_output_monitor
   import event_timer_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // timer
   input wire logic        compare_match_pulse,
   input wire logic [7:0]  event_counter,
   input wire logic        counter_preset,
   input wire logic        fixed_quarter_clock,
   input wire logic        event_out_pin_out,
   input wire logic        event_out_pin_oe
);
   logic take;
   logic wr;
   assign take = hsel && hready && htrans == HTRANS_NONSEQ;
   assign wr   = take && hwrite;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
   a_quarter_tick: assert property (fixed_quarter_clock |=> !fixed_quarter_clock [*3] ##1 fixed_quarter_clock)
      else $error("quarter tick spacing wrong");
   a_match_preset: assert property (compare_match_pulse |-> counter_preset)
      else $error("match without preset");
   a_preset_value: assert property (counter_preset |=> event_counter == COUNT_PRESET)
      else $error("preset value wrong");
   a_count_step: assert property ($changed(event_counter) |-> event_counter == COUNT_PRESET
      || event_counter == $past(event_counter) + 8'h01) else $error("counter jumped");
   a_out_cause: assert property ($changed(event_out_pin_out) |-> $past(compare_match_pulse)
      || $past(wr) || $past(wr, 2)) else $error("output moved without cause");
   a_oe_edge: assert property ($rose(event_out_pin_oe) |-> $past(compare_match_pulse)
      || $past(compare_match_pulse, 2) || $past(wr, 2)) else $error("output on off edge");
   a_clear_reads: assert property (take && !hwrite && haddr[7:0] == STATUS_OFFSET
      |=> !hrdata[STAT_CLEAR_BIT]) else $error("clear bit read one");
   a_reset_pins: assert property ($rose(rst_n) |-> !event_out_pin_oe
      && event_counter == COUNT_PRESET) else $error("reset state wrong");
endmodule // event_timer_clock_and_output_monitor

bind event_timer_clock_and_output event_timer_clock_and_output_monitor u_mon (
   .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .compare_match_pulse(compare_match_pulse), .event_counter(event_counter),
   .counter_preset(counter_preset), .fixed_quarter_clock(fixed_quarter_clock),
   .event_out_pin_out(event_out_pin_out), .event_out_pin_oe(event_out_pin_oe));

// ===== dv/event_pin_model.sv
// external event source and load on the two shared pins
// assumes the bench sets the wanted source level on the system clock
`timescale 1ns/1ps
module event_pin_model (
   // clock
   input wire logic ref_clk,
   // wanted source level
   input wire logic evt_level,
   // device pin drivers
   input wire logic in_out,
   input wire logic in_oe,
   input wire logic out_out,
   input wire logic out_oe,
   // resolved wires
   output logic     event_in_pin,
   output logic     out_wire
);
   logic last_out = 1'b0;
   always_ff @(posedge ref_clk) begin
      if (out_oe) begin
         last_out <= out_out;
      end
   end
   // source steps back whenever the port drives the pin
   assign event_in_pin = in_oe ? in_out : evt_level;
   // an undriven line does not keep its last level
   assign out_wire = out_oe ? out_out : ~last_out;
endmodule // event_pin_model

// ===== dv/event_timer_clock_and_output_tb.sv
// self-checking bench: ahb-lite master, event source and compare pulses
// assumes hreadyout loops back to hready and a 10 MHz clock
`timescale 1ns/1ps
module event_timer_clock_and_output_tb;
   import event_timer_pkg::*;
   logic        ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, cmp = 0, evt = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
   logic [1:0]  htrans = 0;
   logic        hreadyout, hresp, preset, fqc, in_out, in_oe, out_out, out_oe, evin, ow;
   logic [7:0]  cnt, c0, d8;
   int          err_count = 0, num_checks = 0, cyc = 0, n, d;
   event_timer_clock_and_output u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .compare_match_pulse(cmp), .event_counter(cnt), .counter_preset(preset),
      .fixed_quarter_clock(fqc), .event_in_pin(evin), .shared_input_port_pin_out(in_out),
      .shared_input_port_pin_oe(in_oe), .event_out_pin_out(out_out),
      .event_out_pin_oe(out_oe));
   event_pin_model u_pin (.ref_clk(ref_clk), .evt_level(evt), .in_out(in_out),
      .in_oe(in_oe), .out_out(out_out), .out_oe(out_oe), .event_in_pin(evin), .out_wire(ow));
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         test_done();
      end
   end
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dw);
      @(posedge ref_clk);
      hsel <= 1; haddr <= {24'h0, a}; htrans <= HTRANS_NONSEQ; hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= dw;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] dw); ahb(1, a, dw); endtask
   task rd(input logic [7:0] a); ahb(0, a, 32'h0); endtask
   task tick(input int k); repeat (k) @(posedge ref_clk); endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task pulse;
      @(posedge ref_clk) cmp <= 1;
      @(posedge ref_clk) cmp <= 0;
      tick(2 + $urandom_range(0, 3));
   endtask
   function logic [31:0] ctl(input logic s, m, l, o, e);
      return (32'(s) << CTRL_SRC_BIT) | (32'(m) << CTRL_MODE_BIT) | (32'(l) << CTRL_LEVEL_BIT)
         | (32'(o) << CTRL_OE_BIT) | (32'(e) << CTRL_EDGE_BIT);
   endfunction
   function logic [31:0] cexp(input int k); return 32'(COUNT_PRESET) + 32'(k); endfunction
   initial begin
      void'($urandom(32'h690e));
      tick(8);
      rst_n <= 1;
      rd(CTRL_OFFSET); chk(rv, 0);
      rd(PRESCALE_OFFSET); chk(rv, 32'(RATE_RESET));
      rd(STATUS_OFFSET); chk(rv, 0);
      rd(PORT_OFFSET); chk(rv, 0);
      rd(8'h14); chk(rv, 0);
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         d = (r == 0) ? 1 : (r == 1) ? 4 : (r == 2) ? 32 : 256;
         wr(PRESCALE_OFFSET, 32'(r)); wr(COUNT_OFFSET, $urandom);
         rd(PRESCALE_OFFSET); chk(rv, 32'(r));
         rd(COUNT_OFFSET); c0 = rv[7:0];
         tick(40 * d); rd(COUNT_OFFSET); d8 = rv[7:0] - c0;
         chk(d8 >= 40 && d8 <= 44, 1);
      end
      $display("test rates done");
      for (int l = 0; l < 2; l++) begin
         evt <= !l[0]; wr(CTRL_OFFSET, ctl(1, 0, l[0], 0, 0)); tick(4);
         wr(COUNT_OFFSET, $urandom);
         wr(STATUS_OFFSET, 32'h1 << STAT_CLEAR_BIT);
         n = $urandom_range(1, 12);
         repeat (n) begin
            @(posedge ref_clk) evt <= l[0]; tick(4);
            @(posedge ref_clk) evt <= !l[0]; tick(4);
         end
         rd(COUNT_OFFSET); chk(rv, cexp(n));
         rd(STATUS_OFFSET); chk(rv[STAT_FLAG_BIT], 1);
         wr(STATUS_OFFSET, 0); rd(STATUS_OFFSET); chk(rv[STAT_FLAG_BIT], 1);
         wr(STATUS_OFFSET, 32'h1 << STAT_CLEAR_BIT); rd(STATUS_OFFSET);
         chk({rv[STAT_FLAG_BIT], rv[STAT_CLEAR_BIT]}, 0);
      end
      $display("test edge mode done");
      evt <= 0; wr(PRESCALE_OFFSET, 32'(RATE_DIV4)); wr(CTRL_OFFSET, ctl(1, 1, 1, 0, 0));
      wr(COUNT_OFFSET, 0); wr(STATUS_OFFSET, 32'h1 << STAT_CLEAR_BIT);
      @(posedge ref_clk) evt <= 1; tick(40);
      rd(STATUS_OFFSET); chk(rv[STAT_FLAG_BIT], 0);
      @(posedge ref_clk) evt <= 0; tick(40);
      rd(STATUS_OFFSET); chk(rv[STAT_FLAG_BIT], 1);
      rd(COUNT_OFFSET); chk(rv >= cexp(10) && rv <= cexp(12), 1);
      $display("test gated mode done");
      wr(PORT_OFFSET, (32'h1 << PORT_OUT_DIR_BIT) | (32'h1 << PORT_OUT_LATCH_BIT)); tick(1);
      chk({out_oe, ow}, 2'b11);
      wr(PORT_OFFSET, (32'h1 << PORT_IN_DIR_BIT) | (32'h1 << PORT_IN_LATCH_BIT)); tick(3);
      chk({in_oe, in_out}, 2'b11);
      rd(PORT_OFFSET); chk(rv[PORT_IN_PIN_BIT], 1);
      wr(PORT_OFFSET, 0); tick(1); chk({out_oe, in_oe}, 0);
      for (int e = 0; e < 2; e++) begin
         wr(CTRL_OFFSET, ctl(0, 0, 0, 1, e[0])); wr(COUNT_OFFSET, $urandom);
         rd(STATUS_OFFSET); chk({rv[STAT_DIV_BIT], rv[STAT_OUT_ON_BIT], out_oe}, {e[0], 2'b00});
         pulse; chk(out_oe, 0);
         pulse; chk({out_oe, ow}, {1'b1, e[0]});
         wr(CTRL_OFFSET, ctl(0, 0, 0, 0, e[0]));
         pulse; chk({out_oe, ow}, {1'b1, !e[0]});
         pulse; chk(out_oe, 0);
      end
      $display("test event output done");
      test_done();
   end
endmodule // event_timer_clock_and_output_tb
